/* File: common/ccu_pkg.sv */
package ccu_pkg;
  // Register addresses on the plain register port
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CNT_HI = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO = 4'h2;
  localparam logic [3:0] ADDR_LIM_HI = 4'h3;
  localparam logic [3:0] ADDR_LIM_LO = 4'h4;
  localparam logic [3:0] ADDR_CH_CTRL [2] = '{4'h5, 4'h8};
  localparam logic [3:0] ADDR_CH_HI [2] = '{4'h6, 4'h9};
  localparam logic [3:0] ADDR_CH_LO [2] = '{4'h7, 4'hA};
  // main_status_control fields
  localparam int ST_FLAG = 7;
  localparam int ST_IE = 6;
  localparam int ST_HALT = 5;
  localparam int ST_RST = 4;
  localparam logic [2:0] CS_EXT = 3'h7;
  // channel_status_control fields
  localparam int CC_FLAG = 7;
  localparam int CC_IE = 6;
  localparam int CC_MB = 5;
  localparam int CC_MA = 4;
  localparam int CC_EB = 3;
  localparam int CC_EA = 2;
  localparam int CC_TOV = 1;
  localparam int CC_MAX = 0;
  // Values after reset
  localparam logic [15:0] LIMIT_RST = 16'hFFFF;
  localparam logic HALT_RST = 1'b1;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [6:0] CH_CTRL_RST = 7'h00;
  localparam logic [15:0] CH_VAL_RST = 16'h0000;
  // Edge/level codes in output compare mode
  localparam logic [1:0] EL_TOGGLE = 2'h1;
  localparam logic [1:0] EL_CLEAR = 2'h2;
  localparam logic [1:0] EL_SET = 2'h3;
endpackage

/* File: common/ccu_pin_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface ccu_pin_if #(parameter int N = 3);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport drv (output level, output rise, output fall);
  modport use_side (input level, input rise, input fall);
endinterface
`default_nettype wire

/* File: hw/ccu_edge_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module ccu_edge_sync #(
  parameter int N = 3
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [N-1:0] i_raw,
  ccu_pin_if.drv ps
);
  logic [N-1:0] meta_reg;
  logic [N-1:0] sync_reg;
  logic [N-1:0] prev_reg;

  // Two flops per input, then a third for edge detection
  for (genvar k = 0; k < N; k++) begin : g_in
    always_ff @(posedge i_clock) begin
      if (i_rst) begin
        meta_reg[k] <= 1'b0;
        sync_reg[k] <= 1'b0;
        prev_reg[k] <= 1'b0;
      end else begin
        meta_reg[k] <= i_raw[k];
        sync_reg[k] <= meta_reg[k];
        prev_reg[k] <= sync_reg[k];
      end
    end
    assign ps.level[k] = sync_reg[k];
    assign ps.rise[k] = sync_reg[k] & ~prev_reg[k];
    assign ps.fall[k] = ~sync_reg[k] & prev_reg[k];
  end
endmodule // ccu_edge_sync
`default_nettype wire

/* File: hw/ccu_top.sv */
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module ccu_top import ccu_pkg::*; #(
  parameter int PRE_W = 6
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_ext_clock,
  input wire logic [1:0] i_pin,
  output logic [1:0] o_pin_out,
  output logic [1:0] o_pin_oe,
  output logic o_wrap_irq,
  output logic [1:0] o_ch_irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] cnt_reg;
  logic [PRE_W-1:0] pre_reg;
  logic [15:0] lim_reg;
  logic lim_hold_reg;
  logic [2:0] sel_reg;
  logic halt_reg;
  logic wrap_ie_reg;
  logic wrap_flag_reg;
  logic wrap_arm_reg;
  logic [7:0] lo_buf_reg;
  logic lo_latched_reg;
  logic active1_reg;
  logic last1_reg;
  logic [7:0] rdata_reg;
  logic wrap_irq_reg;
  logic [6:0] ctrl_reg [2];
  logic [15:0] val_reg [2];
  logic [1:0] flag_reg;
  logic [1:0] arm_reg;
  logic [1:0] pin_reg;
  logic [1:0] oe_reg;
  logic [1:0] ch_irq_reg;

  logic [PRE_W-1:0] pre_mask;
  logic tick;
  logic at_limit;
  logic wrap_ev;
  logic trst;
  logic link;
  logic wr_status;
  logic [15:0] cmp_val [2];
  logic [1:0] is_oc;
  logic [1:0] is_ic;
  logic [1:0] cap_ev;
  logic [1:0] cmp_ev;
  logic [7:0] rd_mux;

  ccu_pin_if #(.N(3)) pins ();

  ccu_edge_sync #(.N(3)) u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_raw({i_ext_clock, i_pin}),
    .ps(pins.drv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock selection and prescaler
  assign pre_mask = PRE_W'((32'd1 << sel_reg) - 32'd1);
  always_comb begin
    if (halt_reg) begin
      tick = 1'b0;
    end else if (sel_reg == CS_EXT) begin
      tick = pins.rise[2];
    end else begin
      tick = (pre_reg & pre_mask) == pre_mask;
    end
  end

  assign wr_status = i_wr && (i_addr == ADDR_STATUS);
  assign trst = wr_status && i_wdata[ST_RST];
  assign at_limit = (cnt_reg == lim_reg);
  assign wrap_ev = tick && at_limit;
  assign link = ctrl_reg[0][CC_MB];

  always_ff @(posedge i_clock) begin
    if (i_rst || trst) begin
      pre_reg <= '0;
    end else if (!halt_reg) begin
      pre_reg <= pre_reg + PRE_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter; free-running is simply a limit of all ones
  always_ff @(posedge i_clock) begin
    if (i_rst || trst) begin
      cnt_reg <= 16'h0000;
    end else if (wrap_ev) begin
      cnt_reg <= 16'h0000;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Main status and control; a read with the flag set arms the clear
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      halt_reg <= HALT_RST;
      sel_reg <= SEL_RST;
      wrap_ie_reg <= 1'b0;
    end else if (wr_status) begin
      halt_reg <= i_wdata[ST_HALT];
      sel_reg <= i_wdata[2:0];
      wrap_ie_reg <= i_wdata[ST_IE];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wrap_flag_reg <= 1'b0;
      wrap_arm_reg <= 1'b0;
    end else begin
      if (wrap_ev && !lim_hold_reg) begin
        wrap_flag_reg <= 1'b1;
        wrap_arm_reg <= 1'b0;
      end else if (wr_status && wrap_arm_reg && !i_wdata[ST_FLAG]) begin
        wrap_flag_reg <= 1'b0;
        wrap_arm_reg <= 1'b0;
      end else if (i_rd && i_addr == ADDR_STATUS && wrap_flag_reg) begin
        wrap_arm_reg <= 1'b1;
      end else if (wr_status) begin
        wrap_arm_reg <= 1'b0;
      end
    end
  end

  // Limit bytes; a high-byte write holds off the flag until the low byte
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      lim_reg <= LIMIT_RST;
      lim_hold_reg <= 1'b0;
    end else if (i_wr && i_addr == ADDR_LIM_HI) begin
      lim_reg[15:8] <= i_wdata;
      lim_hold_reg <= 1'b1;
    end else if (i_wr && i_addr == ADDR_LIM_LO) begin
      lim_reg[7:0] <= i_wdata;
      lim_hold_reg <= 1'b0;
    end
  end

  // Reading the high byte freezes the low byte for a coherent pair
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      lo_buf_reg <= 8'h00;
      lo_latched_reg <= 1'b0;
    end else if (i_rd && i_addr == ADDR_CNT_HI && !lo_latched_reg) begin
      lo_buf_reg <= cnt_reg[7:0];
      lo_latched_reg <= 1'b1;
    end else if (i_rd && i_addr == ADDR_CNT_LO) begin
      lo_latched_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Linked pair: the pair written last takes over at each wrap
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      last1_reg <= 1'b0;
    end else if (i_wr && (i_addr == ADDR_CH_HI[1] ||
                          i_addr == ADDR_CH_LO[1])) begin
      last1_reg <= 1'b1;
    end else if (i_wr && (i_addr == ADDR_CH_HI[0] ||
                          i_addr == ADDR_CH_LO[0])) begin
      last1_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst || !link) begin
      active1_reg <= 1'b0;
    end else if (wrap_ev) begin
      active1_reg <= last1_reg;
    end
  end

  assign cmp_val[0] = (link && active1_reg) ? val_reg[1] : val_reg[0];
  assign cmp_val[1] = val_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  for (genvar n = 0; n < 2; n++) begin : g_ch
    logic released;
    logic [1:0] mode;
    logic [1:0] el;
    assign released = (n == 1) && link;
    assign mode = ctrl_reg[n][CC_MB:CC_MA];
    assign el = ctrl_reg[n][CC_EB:CC_EA];
    assign is_oc[n] = (mode != 2'h0) && !released;
    assign is_ic[n] = (mode == 2'h0) && !released;
    // Captures are inhibited while the counter is halted
    assign cap_ev[n] = is_ic[n] && !halt_reg &&
                       ((el[0] && pins.rise[n]) ||
                        (el[1] && pins.fall[n]));
    assign cmp_ev[n] = is_oc[n] && tick && (cnt_reg == cmp_val[n]);

    always_ff @(posedge i_clock) begin
      if (i_rst) begin
        ctrl_reg[n] <= CH_CTRL_RST;
      end else if (i_wr && i_addr == ADDR_CH_CTRL[n]) begin
        ctrl_reg[n] <= i_wdata[6:0];
      end
    end

    // A capture wins over a software write in the same cycle
    always_ff @(posedge i_clock) begin
      if (i_rst) begin
        val_reg[n] <= CH_VAL_RST;
      end else if (cap_ev[n]) begin
        val_reg[n] <= cnt_reg;
      end else if (i_wr && i_addr == ADDR_CH_HI[n]) begin
        val_reg[n][15:8] <= i_wdata;
      end else if (i_wr && i_addr == ADDR_CH_LO[n]) begin
        val_reg[n][7:0] <= i_wdata;
      end
    end

    always_ff @(posedge i_clock) begin
      if (i_rst) begin
        flag_reg[n] <= 1'b0;
        arm_reg[n] <= 1'b0;
      end else if (cap_ev[n] || cmp_ev[n]) begin
        flag_reg[n] <= 1'b1;
        arm_reg[n] <= 1'b0;
      end else if (i_wr && i_addr == ADDR_CH_CTRL[n] && arm_reg[n] &&
                   !i_wdata[CC_FLAG]) begin
        flag_reg[n] <= 1'b0;
        arm_reg[n] <= 1'b0;
      end else if (i_rd && i_addr == ADDR_CH_CTRL[n] && flag_reg[n]) begin
        arm_reg[n] <= 1'b1;
      end else if (i_wr && i_addr == ADDR_CH_CTRL[n]) begin
        arm_reg[n] <= 1'b0;
      end
    end

    always_ff @(posedge i_clock) begin
      if (i_rst) begin
        ch_irq_reg[n] <= 1'b0;
      end else begin
        ch_irq_reg[n] <= flag_reg[n] && ctrl_reg[n][CC_IE];
      end
    end

    // Pin: wrap toggles first, a compare in the same tick overrides it.
    // With full duty set the compare is ignored and the pin is held at
    // the pulse level, so the pulse covers the whole period.
    always_ff @(posedge i_clock) begin
      if (i_rst) begin
        pin_reg[n] <= 1'b0;
        oe_reg[n] <= 1'b0;
      end else begin
        oe_reg[n] <= is_oc[n] && (el != 2'h0);
        if (is_oc[n]) begin
          if (cmp_ev[n] && !ctrl_reg[n][CC_MAX]) begin
            unique case (el)
              EL_TOGGLE: pin_reg[n] <= ~pin_reg[n];
              EL_CLEAR: pin_reg[n] <= 1'b0;
              EL_SET: pin_reg[n] <= 1'b1;
              default: pin_reg[n] <= pin_reg[n];
            endcase
          end else if (wrap_ev && ctrl_reg[n][CC_TOV]) begin
            if (ctrl_reg[n][CC_MAX]) begin
              pin_reg[n] <= ~el[0];
            end else begin
              pin_reg[n] <= ~pin_reg[n];
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port
  always_comb begin
    rd_mux = 8'h00;
    unique case (i_addr)
      ADDR_STATUS: rd_mux = {wrap_flag_reg, wrap_ie_reg, halt_reg, 2'b00,
                             sel_reg};
      ADDR_CNT_HI: rd_mux = cnt_reg[15:8];
      ADDR_CNT_LO: rd_mux = lo_latched_reg ? lo_buf_reg : cnt_reg[7:0];
      ADDR_LIM_HI: rd_mux = lim_reg[15:8];
      ADDR_LIM_LO: rd_mux = lim_reg[7:0];
      ADDR_CH_CTRL[0]: rd_mux = {flag_reg[0], ctrl_reg[0]};
      ADDR_CH_HI[0]: rd_mux = val_reg[0][15:8];
      ADDR_CH_LO[0]: rd_mux = val_reg[0][7:0];
      ADDR_CH_CTRL[1]: rd_mux = {flag_reg[1], ctrl_reg[1]};
      ADDR_CH_HI[1]: rd_mux = val_reg[1][15:8];
      ADDR_CH_LO[1]: rd_mux = val_reg[1][7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= i_rd ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wrap_irq_reg <= 1'b0;
    end else begin
      wrap_irq_reg <= wrap_flag_reg && wrap_ie_reg;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_pin_out = pin_reg;
  assign o_pin_oe = oe_reg;
  assign o_wrap_irq = wrap_irq_reg;
  assign o_ch_irq = ch_irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // A status write could change the select or halt, so none may fall
  // inside the window
  sequence s_div4_start;
    tick && sel_reg == 3'h2 && !halt_reg && !wr_status ##1 !wr_status [*3];
  endsequence

  property p_div4;
    s_div4_start |=> tick && !$past(tick) && !$past(tick, 2) &&
                     !$past(tick, 3);
  endproperty
  a_div4: assert property (p_div4)
    else $error("divide-by-4 tick spacing wrong");

  property p_count_up;
    tick && !at_limit && !trst |=> cnt_reg == $past(cnt_reg) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("counter did not step by one");

  property p_wrap;
    wrap_ev && !trst && !lim_hold_reg |=> cnt_reg == 16'h0000 &&
                                          wrap_flag_reg;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap did not clear counter and set flag");

  property p_read_still;
    i_rd && !tick && !trst |=> cnt_reg == $past(cnt_reg);
  endproperty
  a_read_still: assert property (p_read_still)
    else $error("counter moved on a read without a tick");

  property p_capture;
    cap_ev[1] |=> val_reg[1] == $past(cnt_reg) && flag_reg[1];
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not store the counter");

  property p_clear_on_cmp;
    cmp_ev[0] && g_ch[0].el == EL_CLEAR && !ctrl_reg[0][CC_MAX]
      |=> !pin_reg[0];
  endproperty
  a_clear_on_cmp: assert property (p_clear_on_cmp)
    else $error("pin not cleared on compare");

  property p_pwm_toggle;
    wrap_ev && is_oc[0] && ctrl_reg[0][CC_TOV] && !ctrl_reg[0][CC_MAX] &&
      !cmp_ev[0] |=> pin_reg[0] != $past(pin_reg[0]);
  endproperty
  a_pwm_toggle: assert property (p_pwm_toggle)
    else $error("pin did not toggle on wrap");

  property p_full_duty;
    wrap_ev && is_oc[0] && ctrl_reg[0][CC_TOV] && ctrl_reg[0][CC_MAX] &&
      g_ch[0].el == EL_CLEAR |=> pin_reg[0];
  endproperty
  a_full_duty: assert property (p_full_duty)
    else $error("full duty did not hold pin high");

  property p_release;
    link ##1 link |-> !oe_reg[1];
  endproperty
  a_release: assert property (p_release)
    else $error("channel 1 pin driven while linked");

  property p_swap;
    link && wrap_ev |=> active1_reg == $past(last1_reg);
  endproperty
  a_swap: assert property (p_swap)
    else $error("linked pair did not pass control at wrap");
endmodule // ccu_top
`default_nettype wire

/* File: sim/ccu_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ccu_pin_model (
  input wire logic i_clock,
  input wire logic [1:0] i_pin_out,
  input wire logic [1:0] i_pin_oe,
  output logic o_ext_clock,
  output logic [1:0] o_pin_wire
);
  logic [1:0] drive_reg;

  initial begin
    o_ext_clock = 1'b0;
    drive_reg = 2'h0;
  end

  // The block wins the wire wherever it enables its driver
  assign o_pin_wire = (i_pin_oe & i_pin_out) | (~i_pin_oe & drive_reg);

  //////////////////////////////////////////////////////////////////////////
  task automatic set_pin(input int ch, input logic lvl);
    @(posedge i_clock);
    drive_reg[ch] <= lvl;
  endtask

  // Pulses wide enough for the three-flop synchroniser; idle low between
  task automatic clock_pulses(input int n);
    repeat (n) begin
      @(posedge i_clock);
      o_ext_clock <= 1'b1;
      repeat (4) @(posedge i_clock);
      o_ext_clock <= 1'b0;
      repeat (3) @(posedge i_clock);
    end
  endtask
endmodule // ccu_pin_model
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench import ccu_pkg::*;;
  logic i_clock, i_rst, i_wr, i_rd, o_wrap_irq, ext_clock;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, d8;
  logic [1:0] o_pin_out, o_pin_oe, o_ch_irq, pin_wire;
  logic [15:0] v;
  int failures, n_compared, cycles;
  localparam logic [3:0] RA [7] = '{ADDR_STATUS, ADDR_CNT_LO, ADDR_LIM_HI,
    ADDR_LIM_LO, 4'h5, 4'h9, 4'hB};
  localparam logic [7:0] RE [7] = '{8'h20, 8'h00, 8'hFF, 8'hFF, 8'h00,
    8'h00, 8'h00};
  localparam logic [1:0] ELS [3] = '{EL_SET, EL_CLEAR, EL_TOGGLE};
  localparam logic EXP [3] = '{1'b1, 1'b0, 1'b1};
  // Row: address, data, run length, expected channel 0 pin
  localparam logic [16:0] ROWS [9] = '{
    {4'h5, 8'h1A, 4'd6, 1'b1}, {4'h5, 8'h1A, 4'd4, 1'b0},
    {4'h5, 8'h18, 4'd6, 1'b0}, {4'h5, 8'h1B, 4'd6, 1'b1},
    {4'h5, 8'h1B, 4'd4, 1'b1}, {4'hA, 8'h01, 4'd6, 1'b1},
    {4'h4, 8'h05, 4'd2, 1'b0}, {4'h7, 8'h04, 4'd6, 1'b1},
    {4'h4, 8'h05, 4'd2, 1'b1}};

  always #5 i_clock = ~i_clock;

  ccu_top #(.PRE_W(6)) DUT (.i_clock(i_clock), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_ext_clock(ext_clock), .i_pin(pin_wire),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_wrap_irq(o_wrap_irq),
    .o_ch_irq(o_ch_irq));

  ccu_pin_model PM (.i_clock(i_clock), .i_pin_out(o_pin_out),
    .i_pin_oe(o_pin_oe), .o_ext_clock(ext_clock), .o_pin_wire(pin_wire));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t ns: seen 0x%0h expected 0x%0h", $time, seen,
        exp);
    end
  endtask

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_clock);
  endtask

  task automatic rd16(input logic [3:0] ah, input logic [3:0] al,
      output logic [15:0] val);
    logic [7:0] h;
    logic [7:0] l;
    rd(ah, h);
    rd(al, l);
    val = {h, l};
  endtask

  // Counter runs for exactly n clock cycles, giving n >> sel ticks on the prescaler
  task automatic run(input int n, input logic [7:0] st);
    logic [15:0] dummy;
    wr(ADDR_STATUS, 8'h30 | st);
    wr(ADDR_STATUS, st);
    if (n >= 8) begin
      rd16(ADDR_CNT_HI, ADDR_CNT_LO, dummy);
      repeat (n - 6) @(posedge i_clock);
    end else begin
      repeat (n - 2) @(posedge i_clock);
    end
    wr(ADDR_STATUS, 8'h20 | st);
  endtask

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      give_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int k = 0; k < 7; k++) begin
      rd(RA[k], d8);
      check(d8, RE[k]);
    end
    for (int s = 0; s < 7; s++) begin
      run(128, 8'(s));
      rd16(ADDR_CNT_HI, ADDR_CNT_LO, v);
      check(v, 16'(128 >> s));
    end
    wr(ADDR_LIM_HI, 8'h00);
    wr(ADDR_LIM_LO, 8'h05);
    run(8, 8'h40);
    rd16(ADDR_CNT_HI, ADDR_CNT_LO, v);
    check(v, 16'h0002);
    rd(ADDR_STATUS, d8);
    check({d8, 7'h00, o_wrap_irq}, 16'hE001);
    wr(ADDR_STATUS, 8'h20);
    rd(ADDR_STATUS, d8);
    check({d8, 7'h00, o_wrap_irq}, 16'h2000);
    for (int ch = 0; ch < 2; ch++) begin
      wr(ADDR_CH_LO[ch], 8'h03);
      for (int k = 0; k < 3; k++) begin
        wr(ADDR_CH_CTRL[ch], {4'h5, ELS[k], 2'b00});
        run(6, 8'h00);
        rd(ADDR_CH_CTRL[ch], d8);
        check(d8, {4'hD, ELS[k], 2'b00});
        v = {13'h0000, o_pin_out[ch], o_pin_oe[ch], o_ch_irq[ch]};
        check(v, {13'h0000, EXP[k], 2'b11});
      end
    end
    for (int k = 0; k < 9; k++) begin
      if (k == 5) begin
        wr(ADDR_CH_CTRL[1], 8'h1C);
        wr(ADDR_CH_CTRL[0], 8'h3A);
      end
      // Linked rows write either the inactive pair or the limit low byte
      wr(ROWS[k][16:13], ROWS[k][12:5]);
      run(int'(ROWS[k][4:1]), 8'h00);
      check(o_pin_out[0], ROWS[k][0]);
      check(o_pin_oe[0], 1'b1);
    end
    check(o_pin_oe, 2'b01);
    wr(ADDR_CH_CTRL[0], 8'h00);
    for (int code = 1; code < 4; code++) begin
      PM.set_pin(1, 1'b1);
      wr(ADDR_CH_CTRL[1], {4'h4, 2'(code), 2'b00});
      wr(ADDR_STATUS, 8'h36);
      wr(ADDR_STATUS, 8'h06);
      repeat (97) @(posedge i_clock);
      PM.set_pin(1, 1'b0);
      repeat (127) @(posedge i_clock);
      PM.set_pin(1, 1'b1);
      repeat (10) @(posedge i_clock);
      wr(ADDR_STATUS, 8'h26);
      rd16(ADDR_CH_HI[1], ADDR_CH_LO[1], v);
      check(v, (code == 2) ? 16'h0001 : 16'h0003);
      check({o_ch_irq[1], o_pin_oe[1]}, 2'b10);
    end
    wr(ADDR_STATUS, 8'h37);
    wr(ADDR_STATUS, 8'h07);
    PM.clock_pulses(7);
    repeat (6) @(posedge i_clock);
    wr(ADDR_STATUS, 8'h27);
    rd16(ADDR_CNT_HI, ADDR_CNT_LO, v);
    check(v, 16'h0001);
    rd(ADDR_STATUS, d8);
    check(d8, 8'hA7);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
